// [lpw_bit_engine.sv]
// Two-wire bit engine: synchronises both lines, finds start, stop and clock edges.
// Assumes raw pin levels; the register file drives data via the enable output only.
`timescale 1ns/1ps
`default_nettype none
module lpw_bit_engine
    import lpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_lvl,
    output logic sda_lvl,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;

    // Only the second stage is looked at, the first only feeds it.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign scl_lvl = scl_sync_q[1];
    assign sda_lvl = sda_sync_q[1];
    assign scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign scl_fall = !scl_sync_q[1] && scl_prev_q;
    assign start_det = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
    assign stop_det = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
endmodule
`default_nettype wire

// [lpw_master_model.sv]
// Behavioural two-wire bus master that stands on the far side of the slave.
// Assumes an open-drain data wire with a pull-up resolved in the bench.
`timescale 1ns/1ps
`default_nettype none
module lpw_master_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl_o,
    output logic sda_low
);
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end

    // One quarter of a 400 ns bus clock period; all changes land on falling edges.
    task automatic q();
        repeat (2) @(negedge clk_sys);
    endtask

    // Works from idle and as a repeated start right after an acknowledge clock.
    task automatic start();
        sda_low = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask

    task automatic stop();
        sda_low = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask

    task automatic bit_x(input logic b, output logic r);
        sda_low = !b;
        q();
        scl_o = 1'b1;
        q();
        r = sda_line;
        q();
        scl_o = 1'b0;
        q();
    endtask

    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // A not-acknowledge on the last byte hands the data wire back to the master.
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!ack, r);
    endtask

    // Pulls both lines low and leaves them there; a stop releases them.
    task automatic hold_low(input int n);
        sda_low = 1'b1;
        q();
        scl_o = 1'b0;
        repeat (n) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [lpw_pkg.sv]
// Constants shared by the two-wire slave, its bit engine and the wakeup controller.
// Assumes a 20 MHz system clock and a bus master no faster than 400 kHz.
// How it works
// [RULE1] The clock line is only ever read; no output can pull it low.
// [RULE2] Bus clock up to 400 kHz is sampled comfortably by the 20 MHz clock.
// [RULE3] Address byte 80h selects writes, 81h selects reads; others are ignored.
// [RULE4] A write begins with start, write address, then an eight-bit pointer byte.
// [RULE5] Each following data byte is stored at the pointer, then the pointer advances; during wakeup a following byte overwrites the still-pending one.
// [RULE6] Master turns direction by repeated start or fresh start plus read address.
// [RULE7] Right after the read address the device sends a byte, advancing per byte.
// [RULE8] Master issues the repeated start on the first pulse after pointer acknowledge.
// [RULE9] After repeated start the device sends the register named by the last pointer.
// [RULE10] Single-byte read ends with master not-acknowledge and stop.
// [RULE11] Device keeps sending successive registers while the master acknowledges.
// [RULE12] Master ends a multi-byte read with not-acknowledge then stop.
// [RULE13] Start then read address reads from the existing pointer.
// [RULE14] Both lines low past debounce enters shutdown and resets all registers.
// [RULE15] Either line high enables the interface and enters standby.
// [RULE16] Standby and normal mode follow whether any functional block is active.
// [RULE17] With the oscillator running a write applies within one internal cycle.
// [RULE18] With everything off an enabling write waits 64 internal cycles.
// [RULE19] The both-low condition must persist for the debounce period first.
// [RULE20] Bus-low shutdown only when shutdown-enable is set, lines low 120 ms.
// [RULE21] Device acknowledges each accepted address, pointer and data byte.
// [RULE22] The pointer wraps modulo 256 on increment.
package lpw_pkg;
    localparam logic [6:0] LPW_DEV_ADDR = 7'h40;
    localparam int LPW_CLK_HZ = 20000000;
    localparam int LPW_BUS_MAX_HZ = 400000;
    localparam int LPW_DEB_MS = 120;
    localparam int LPW_DEB_CYC = LPW_CLK_HZ / 1000 * LPW_DEB_MS;
    localparam int LPW_OSC_US = 1;
    localparam int LPW_OSC_DIV = LPW_CLK_HZ / 1000000 * LPW_OSC_US;
    localparam int LPW_WAKE_CYC = 64;
    localparam logic [7:0] LPW_PTR_RST = 8'h00;
    localparam logic [7:0] LPW_REG_RST = 8'h00;
    typedef enum logic [1:0] {LPW_SHUTDOWN, LPW_STANDBY, LPW_WAKING, LPW_NORMAL} lpw_mode_t;
endpackage

// [lpw_slave.sv]
// Two-wire serial slave with an auto-incrementing 256-byte register file and
// the shutdown and wakeup logic it drives.
// Assumes a bus master that keeps fast-mode timing and the open-drain data wire
// resolved outside from sda_oe; the clock line is input only.
`timescale 1ns/1ps
`default_nettype none
module lpw_slave
    import lpw_pkg::*;
#(
    parameter int DEB_CYC = LPW_DEB_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic shutdown_en,
    output logic [7:0] ctrl_q,
    output logic [1:0] mode_q,
    output logic [7:0] pointer_q
);
    typedef enum logic [2:0] {
        LPW_S_IDLE, LPW_S_ADDR, LPW_S_PTR, LPW_S_WDATA, LPW_S_ACK, LPW_S_RDATA, LPW_S_RACK
    } lpw_state_t;

    logic scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det;
    logic bus_reset, osc_ready, any_active, enable_req;
    lpw_mode_t mode;
    lpw_state_t state_q, next_q;
    logic [7:0] regs_q [256];
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic is_read_q;
    logic ack_drive_q;
    logic [7:0] tx_q;
    logic pend_q;
    logic [7:0] pend_addr_q;
    logic [7:0] pend_data_q;
    logic [7:0] shift_in;

    lpw_bit_engine u_bits (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_lvl(scl_lvl),
        .sda_lvl(sda_lvl),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // Register 00h is treated as the block-enable register; nonzero means active.
    assign any_active = (regs_q[0] != 8'h00); // RULE16
    // In standby, only a nonzero write to the block-enable register has to wait for the oscillator.
    assign enable_req = pend_q && (pend_addr_q == 8'h00) && (pend_data_q != 8'h00) &&
        !any_active;

    lpw_wakeup #(
        .DEB_CYC(DEB_CYC)
    ) u_wake (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl_lvl(scl_lvl),
        .sda_lvl(sda_lvl),
        .shutdown_en(shutdown_en),
        .any_active(any_active),
        .enable_req(enable_req),
        .bus_reset(bus_reset),
        .osc_ready(osc_ready),
        .mode(mode)
    );

    assign shift_in = {shift_q[6:0], sda_lvl};

    // Bit and byte sequencing; sampling on the rising clock edge.
    always_ff @(posedge clk_sys) begin
        if (!resetn || bus_reset) begin // RULE14
            state_q <= LPW_S_IDLE;
            next_q <= LPW_S_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            is_read_q <= 1'b0;
        end else if (start_det) begin // RULE4
            state_q <= LPW_S_ADDR;
            bit_q <= 4'h0;
        end else if (stop_det) begin
            state_q <= LPW_S_IDLE;
        end else if (scl_rise) begin
            case (state_q)
                LPW_S_ADDR, LPW_S_PTR, LPW_S_WDATA: begin
                    shift_q <= shift_in;
                    bit_q <= bit_q + 4'h1;
                end
                LPW_S_RDATA: bit_q <= bit_q + 4'h1;
                LPW_S_RACK: begin
                    // A not-acknowledge releases the bus until the next start.
                    state_q <= sda_lvl ? LPW_S_IDLE : LPW_S_RDATA; // RULE11
                    bit_q <= 4'h0;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                case (state_q)
                    LPW_S_ADDR: if (shift_q[7:1] == LPW_DEV_ADDR) begin // RULE3
                        is_read_q <= shift_q[0];
                        state_q <= LPW_S_ACK;
                        next_q <= shift_q[0] ? LPW_S_RDATA : LPW_S_PTR; // RULE13
                    end else begin
                        state_q <= LPW_S_IDLE;
                    end
                    LPW_S_PTR, LPW_S_WDATA: begin
                        state_q <= LPW_S_ACK;
                        next_q <= LPW_S_WDATA;
                    end
                    LPW_S_RDATA: state_q <= LPW_S_RACK;
                    default: ;
                endcase
            end else if (state_q == LPW_S_ACK) begin
                state_q <= next_q;
            end
        end
    end

    // Pointer: loaded by the pointer byte, advanced after each data byte.
    always_ff @(posedge clk_sys) begin
        if (!resetn || bus_reset) begin
            pointer_q <= LPW_PTR_RST;
        end else if (scl_fall && bit_q == 4'h8) begin
            if (state_q == LPW_S_PTR) begin
                pointer_q <= shift_q; // RULE9
            end else if (state_q == LPW_S_WDATA || state_q == LPW_S_RDATA) begin
                pointer_q <= pointer_q + 8'h01; // RULE22
            end
        end
    end

    // Written bytes wait here for an oscillator tick in normal mode, except non-enabling ones in standby.
    always_ff @(posedge clk_sys) begin
        if (!resetn || bus_reset) begin
            pend_q <= 1'b0;
            pend_addr_q <= 8'h00;
            pend_data_q <= 8'h00;
        end else if (scl_fall && bit_q == 4'h8 && state_q == LPW_S_WDATA) begin
            pend_q <= 1'b1; // RULE5
            pend_addr_q <= pointer_q;
            pend_data_q <= shift_q;
        end else if (pend_q && (osc_ready || (mode == LPW_STANDBY && !enable_req))) begin
            pend_q <= 1'b0;
        end
    end

    // Standby writes that enable nothing need no oscillator; they land at once.
    // A back-to-back byte during wakeup overwrites the pending one, a known limit.
    always_ff @(posedge clk_sys) begin
        if (!resetn || bus_reset) begin
            for (int i = 0; i < 256; i++) begin
                regs_q[i] <= LPW_REG_RST; // RULE14
            end
        end else if (pend_q && (osc_ready || (mode == LPW_STANDBY && !enable_req))) begin
            regs_q[pend_addr_q] <= pend_data_q; // RULE17
        end
    end

    // Data line driver: acknowledge or transmitted bit, changed on falling edges.
    always_ff @(posedge clk_sys) begin
        if (!resetn || bus_reset) begin
            ack_drive_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_det || stop_det) begin
            ack_drive_q <= 1'b0;
        end else if (scl_fall) begin
            if (bit_q == 4'h8 && state_q != LPW_S_RDATA && state_q != LPW_S_RACK &&
                (state_q != LPW_S_ADDR || shift_q[7:1] == LPW_DEV_ADDR)) begin
                ack_drive_q <= 1'b1; // RULE21
            end else if (state_q == LPW_S_ACK && next_q == LPW_S_RDATA) begin
                ack_drive_q <= !regs_q[pointer_q][7]; // RULE7
                tx_q <= {regs_q[pointer_q][6:0], 1'b0};
            end else if (state_q == LPW_S_RDATA && bit_q != 4'h8) begin
                ack_drive_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end else if (state_q == LPW_S_RDATA) begin
                // The master owns the acknowledge slot after the last data bit.
                ack_drive_q <= 1'b0; // RULE11
            end else if (state_q == LPW_S_RACK) begin
                ack_drive_q <= 1'b0;
            end else if (state_q == LPW_S_ACK) begin
                ack_drive_q <= 1'b0;
            end
        end else if (scl_rise && state_q == LPW_S_RACK && !sda_lvl) begin
            tx_q <= regs_q[pointer_q]; // RULE11
        end
    end

    // The first bit of a continued read goes out on the next falling edge.
    assign sda_o = 1'b0;
    assign sda_oe = ack_drive_q; // RULE1

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_q <= LPW_REG_RST;
            mode_q <= 2'h1;
        end else begin
            ctrl_q <= regs_q[0];
            mode_q <= mode;
        end
    end

    a_ack_after_addr: assert property (@(posedge clk_sys) disable iff (!resetn || bus_reset)
        (scl_fall && bit_q == 4'h8 && state_q == LPW_S_ADDR && shift_q[7:1] == LPW_DEV_ADDR
         && !start_det && !stop_det) |=> sda_oe) // RULE21
        else $error("address byte not acknowledged");
    a_ptr_load: assert property (@(posedge clk_sys) disable iff (!resetn || bus_reset)
        (scl_fall && bit_q == 4'h8 && state_q == LPW_S_PTR && !start_det && !stop_det)
        |=> pointer_q == $past(shift_q)) // RULE4
        else $error("pointer byte not loaded");
    a_ptr_incr: assert property (@(posedge clk_sys) disable iff (!resetn || bus_reset)
        (scl_fall && bit_q == 4'h8 && state_q == LPW_S_RDATA && !start_det && !stop_det)
        |=> pointer_q == $past(pointer_q) + 8'h01) // RULE22
        else $error("pointer did not advance after a read byte");
    a_wrong_addr: assert property (@(posedge clk_sys) disable iff (!resetn || bus_reset)
        (scl_fall && bit_q == 4'h8 && state_q == LPW_S_ADDR && shift_q[7:1] != LPW_DEV_ADDR
         && !start_det && !stop_det) |=> state_q == LPW_S_IDLE && !sda_oe) // RULE3
        else $error("foreign address answered");
    a_wr_pending: assert property (@(posedge clk_sys) disable iff (!resetn || bus_reset)
        (scl_fall && bit_q == 4'h8 && state_q == LPW_S_WDATA && !start_det && !stop_det)
        |=> pend_q && pend_addr_q == $past(pointer_q)) // RULE5
        else $error("written byte not captured");
    a_reset_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        bus_reset |=> ##1 ctrl_q == LPW_REG_RST && pointer_q == LPW_PTR_RST) // RULE14
        else $error("shutdown did not clear registers");
endmodule
`default_nettype wire

// [lpw_wakeup.sv]
// Operating-mode controller: bus-low shutdown debounce and oscillator wakeup delay.
// Assumes synchronised line levels and an activity flag from the register file.
`timescale 1ns/1ps
`default_nettype none
module lpw_wakeup
    import lpw_pkg::*;
#(
    parameter int DEB_CYC = LPW_DEB_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_lvl,
    input wire logic sda_lvl,
    input wire logic shutdown_en,
    input wire logic any_active,
    input wire logic enable_req,
    output logic bus_reset,
    output logic osc_ready,
    output lpw_mode_t mode
);
    logic [31:0] deb_cnt_q;
    logic [31:0] osc_cnt_q;
    logic [6:0] wake_cnt_q;
    logic osc_tick;
    lpw_mode_t mode_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            deb_cnt_q <= 32'h0;
        end else if (scl_lvl || sda_lvl || !shutdown_en) begin // RULE20
            deb_cnt_q <= 32'h0;
        end else if (deb_cnt_q < 32'(DEB_CYC)) begin // RULE19
            deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end
    assign bus_reset = (deb_cnt_q >= 32'(DEB_CYC)); // RULE14

    // The internal oscillator is modelled as a divided tick of the system clock.
    always_ff @(posedge clk_sys) begin
        if (!resetn || osc_tick) begin
            osc_cnt_q <= 32'h0;
        end else begin
            osc_cnt_q <= osc_cnt_q + 32'h1;
        end
    end
    assign osc_tick = (osc_cnt_q == 32'(LPW_OSC_DIV - 1));

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mode_q <= LPW_STANDBY;
            wake_cnt_q <= 7'h0;
        end else if (bus_reset) begin
            mode_q <= LPW_SHUTDOWN;
            wake_cnt_q <= 7'h0;
        end else begin
            case (mode_q)
                LPW_SHUTDOWN: if (scl_lvl || sda_lvl) begin // RULE15
                    mode_q <= LPW_STANDBY;
                end
                LPW_STANDBY: if (enable_req) begin // RULE18
                    mode_q <= LPW_WAKING;
                    wake_cnt_q <= 7'h0;
                end
                LPW_WAKING: if (osc_tick) begin
                    if (wake_cnt_q == 7'(LPW_WAKE_CYC - 1)) begin // RULE18
                        mode_q <= LPW_NORMAL;
                    end
                    wake_cnt_q <= wake_cnt_q + 7'h1;
                end
                LPW_NORMAL: if (!any_active && !enable_req) begin // RULE16
                    mode_q <= LPW_STANDBY;
                end
                default: mode_q <= LPW_STANDBY;
            endcase
        end
    end
    assign mode = mode_q;
    // Writes are applied on the next oscillator tick once running.
    assign osc_ready = (mode_q == LPW_NORMAL) && osc_tick; // RULE17

    a_wake_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mode_q == LPW_STANDBY && enable_req && !bus_reset) |=> (mode_q == LPW_WAKING)[*8]) // RULE18
        else $error("wakeup skipped the oscillator delay");
    a_no_shutdown_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        (scl_lvl || sda_lvl) |=> !bus_reset) // RULE15
        else $error("shutdown while a line is high");
    a_shutdown_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        !shutdown_en |=> !bus_reset) // RULE20
        else $error("shutdown without enable");
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the two-wire slave with its shutdown and wakeup logic.
// Assumes lpw_master_model as bus partner and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpw_pkg::*;
    localparam int DEB = 200;
    localparam logic [15:0] ROWS [3] = '{16'h1055, 16'h11a5, 16'hff3c};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic shutdown_en = 1'b0;
    logic scl_o, sda_low, sda_o, sda_oe, sda_line, a;
    logic [7:0] ctrl_q, pointer_q, d;
    logic [1:0] mode_q;
    int bad_count = 0;
    int n_checks = 0;

    always #25 clk_sys = ~clk_sys;
    assign sda_line = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    lpw_slave #(.DEB_CYC(DEB)) i_lpw_slave (.clk_sys(clk_sys), .resetn(resetn),
        .scl_i(scl_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .shutdown_en(shutdown_en), .ctrl_q(ctrl_q), .mode_q(mode_q), .pointer_q(pointer_q));
    lpw_master_model i_lpw_master_model (.clk_sys(clk_sys), .sda_line(sda_line),
        .scl_o(scl_o), .sda_low(sda_low));

    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic mode_is(input logic [1:0] exp);
        chk8({6'h00, mode_q}, {6'h00, exp});
    endtask

    task automatic wreg(input logic [7:0] ptr, input logic [7:0] dat);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h80, a);
        chk8({7'h00, a}, 8'h01);
        i_lpw_master_model.wr(ptr, a);
        chk8({7'h00, a}, 8'h01);
        i_lpw_master_model.wr(dat, a);
        chk8({7'h00, a}, 8'h01);
        i_lpw_master_model.stop();
    endtask

    // Random read: pointer write, repeated start, read address, one byte, nack.
    task automatic rreg(input logic [7:0] ptr, input logic [7:0] exp);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h80, a);
        i_lpw_master_model.wr(ptr, a);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h81, a);
        chk8({7'h00, a}, 8'h01);
        i_lpw_master_model.rd(1'b0, d);
        chk8(d, exp);
        i_lpw_master_model.stop();
    endtask

    task automatic wait_ctrl(input logic [7:0] exp, input int lim);
        int n;
        n = 0;
        while (ctrl_q !== exp && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk8({sda_oe, ctrl_q[6:0]}, 8'h00);
        chk8(pointer_q, LPW_PTR_RST);
        mode_is(2'd1);
        for (int i = 0; i < 3; i++) begin
            wreg(ROWS[i][15:8], ROWS[i][7:0]);
            rreg(ROWS[i][15:8], ROWS[i][7:0]);
        end
        rreg(8'h10, 8'h55);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h81, a);
        i_lpw_master_model.rd(1'b0, d);
        i_lpw_master_model.stop();
        chk8(d, 8'ha5);
        chk8(pointer_q, 8'h12);
        // Page write across the top of the register space.
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h80, a);
        i_lpw_master_model.wr(8'hfd, a);
        for (int i = 1; i <= 3; i++) begin
            i_lpw_master_model.wr(8'(i * 8'h11), a);
            chk8({7'h00, a}, 8'h01);
        end
        i_lpw_master_model.stop();
        chk8(pointer_q, 8'h00);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h80, a);
        i_lpw_master_model.wr(8'hfd, a);
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h81, a);
        for (int i = 1; i <= 3; i++) begin
            i_lpw_master_model.rd(i < 3, d);
            chk8(d, 8'(i * 8'h11));
        end
        i_lpw_master_model.stop();
        chk8(pointer_q, 8'h00);
        // A foreign address must be left unanswered.
        i_lpw_master_model.start();
        i_lpw_master_model.wr(8'h82, a);
        chk8({7'h00, a}, 8'h00);
        i_lpw_master_model.stop();
        // Enabling a block from standby waits for the oscillator start.
        wreg(8'h00, 8'h01);
        repeat (1000) @(negedge clk_sys);
        chk8(ctrl_q, 8'h00);
        mode_is(2'd2);
        wait_ctrl(8'h01, 600);
        repeat (2) @(negedge clk_sys);
        mode_is(2'd3);
        wreg(8'h00, 8'h03);
        wait_ctrl(8'h03, 60);
        wreg(8'h00, 8'h00);
        wait_ctrl(8'h00, 60);
        repeat (5) @(negedge clk_sys);
        mode_is(2'd1);
        // Bus-low shutdown: too short, enabled, then disabled.
        shutdown_en = 1'b1;
        i_lpw_master_model.hold_low(DEB - 50);
        mode_is(2'd1);
        i_lpw_master_model.stop();
        i_lpw_master_model.hold_low(DEB + 60);
        mode_is(2'd0);
        i_lpw_master_model.stop();
        repeat (10) @(negedge clk_sys);
        mode_is(2'd1);
        rreg(8'h10, LPW_REG_RST);
        wreg(8'h11, 8'ha5);
        shutdown_en = 1'b0;
        i_lpw_master_model.hold_low(DEB + 60);
        mode_is(2'd1);
        i_lpw_master_model.stop();
        rreg(8'h11, 8'ha5);
        report_and_stop();
    end
endmodule
`default_nettype wire
